//--- rtl/rpra_core.sv
`timescale 1ns/100ps
module rpra_core (
  input wire logic CLK,
  input wire logic RESET,
  input rpra_pkg::rpra_flow_cmd_type FLOW_CMD,
  input rpra_pkg::rpra_data_cmd_type DATA_CMD,
  input wire logic [rpra_pkg::ROM_W-1:0] SEG_PORT,
  input wire logic PROG_WE,
  input wire logic [rpra_pkg::PC_W-1:0] PROG_ADDR,
  input wire logic [rpra_pkg::ROM_W-1:0] PROG_DATA,
  output logic CYCLE,
  output logic [rpra_pkg::PC_W-1:0] PC,
  output logic [rpra_pkg::ROM_W-1:0] INSTR,
  output logic [rpra_pkg::NIB_W-1:0] WORK_NIBBLE,
  output logic [rpra_pkg::PTR_W-1:0] RAM_PTR,
  output logic [rpra_pkg::DIG_W-1:0] STROBE,
  output logic [rpra_pkg::NIB_W-1:0] OUT_LATCH,
  output logic SKIP
);

  //==========================================================================
  // State
  //==========================================================================
  logic [7:0] div_reg;                          // Cycle divider
  logic cyc_reg;                                // Cycle pulse register
  logic [rpra_pkg::PC_W-1:0] pc_reg;            // Program counter
  logic [rpra_pkg::PC_W-1:0] pc_next;
  logic [rpra_pkg::PC_W-1:0] slot_one_reg;      // Most recent return
  logic [rpra_pkg::PC_W-1:0] slot_one_next;
  logic [rpra_pkg::PC_W-1:0] slot_two_reg;      // Older return
  logic [rpra_pkg::PC_W-1:0] slot_two_next;
  logic [rpra_pkg::ROM_W-1:0] instr_reg;        // Fetched word
  logic [rpra_pkg::NIB_W-1:0] work_reg;         // Work nibble
  logic [rpra_pkg::NIB_W-1:0] work_next;
  logic [rpra_pkg::PTR_W-1:0] ptr_reg;          // Data pointer
  logic [rpra_pkg::PTR_W-1:0] ptr_next;
  logic [rpra_pkg::DIG_W-1:0] strobe_reg;       // Strobe copy of digit
  logic [rpra_pkg::NIB_W-1:0] latch_reg;        // Output latch
  logic [rpra_pkg::NIB_W-1:0] latch_next;
  logic skip_reg;                               // Skip condition
  logic skip_next;

  // Program store, flip-flops loaded through the program port
  logic [rpra_pkg::ROM_W-1:0] rom [rpra_pkg::ROM_WORDS];

  //==========================================================================
  // Functions
  //==========================================================================
  // Page-relative address: page from the counter, offset from operand
  function automatic logic [rpra_pkg::PC_W-1:0] page_addr(
    input logic [rpra_pkg::PC_W-1:0] base,
    input logic [rpra_pkg::PC_W-1:0] offs
  );
    page_addr = {base[rpra_pkg::PC_W-1 -: rpra_pkg::PAGE_BITS],
                 offs[rpra_pkg::OFFS_BITS-1:0]};
  endfunction

  //==========================================================================
  // Instruction cycle enable
  //==========================================================================
  wire logic cycle_en = (div_reg == rpra_pkg::DIV_LAST);

  // Free-running divider; one enable pulse per instruction cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_reg <= 8'h00;
      cyc_reg <= 1'b0;
    end else begin
      div_reg <= cycle_en ? 8'h00 : div_reg + 8'h01;
      cyc_reg <= cycle_en;
    end
  end

  //==========================================================================
  // Program flow
  //==========================================================================
  wire rpra_pkg::rpra_flow_op_type fop = FLOW_CMD.op;
  wire logic [rpra_pkg::PC_W-1:0] pc_inc = pc_reg + 9'h001;
  wire logic [rpra_pkg::PC_W-1:0] pc_page =
    page_addr(pc_reg, FLOW_CMD.target);
  // Indirect: the word at the page offset names a new offset
  wire logic [rpra_pkg::ROM_W-1:0] ind_word = rom[pc_page];
  wire logic [rpra_pkg::PC_W-1:0] pc_ind =
    page_addr(pc_reg, {1'b0, ind_word});
  wire logic is_call = (fop == rpra_pkg::PC_CALL) ||
                       (fop == rpra_pkg::PC_PAGE_CALL);
  wire logic is_ret = (fop == rpra_pkg::PC_RET);

  // Next counter value; the binary value is used as the word address
  always_comb begin
    unique case (fop)
      rpra_pkg::PC_JUMP: pc_next = FLOW_CMD.target;
      rpra_pkg::PC_CALL: pc_next = FLOW_CMD.target;
      rpra_pkg::PC_PAGE_JUMP: pc_next = pc_page;
      rpra_pkg::PC_PAGE_CALL: pc_next = pc_page;
      rpra_pkg::PC_RET: pc_next = slot_one_reg;
      rpra_pkg::PC_INDIRECT: pc_next = pc_ind;
      default: pc_next = pc_inc;
    endcase
  end

  // Stack: a third nested call overwrites the oldest level
  assign slot_one_next = is_call ? pc_inc :
                         is_ret ? slot_two_reg : slot_one_reg;
  assign slot_two_next = is_call ? slot_one_reg : slot_two_reg;

  // Counter and stack step once per instruction cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pc_reg <= rpra_pkg::PC_RESET;
      slot_one_reg <= rpra_pkg::PC_RESET;
      slot_two_reg <= rpra_pkg::PC_RESET;
    end else if (cycle_en) begin
      pc_reg <= pc_next;
      slot_one_reg <= slot_one_next;
      slot_two_reg <= slot_two_next;
    end
  end

  // Fetch the word at the new address as the counter loads
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      instr_reg <= 8'h00;
    end else if (cycle_en) begin
      instr_reg <= rom[pc_next];
    end
  end

  // Program load port; no reset so contents survive
  always_ff @(posedge CLK) begin
    if (PROG_WE) begin
      rom[PROG_ADDR] <= PROG_DATA;
    end
  end

  //==========================================================================
  // Data addressing
  //==========================================================================
  wire rpra_pkg::rpra_data_op_type dop = DATA_CMD.op;
  wire logic is_direct = (dop == rpra_pkg::DM_DIRECT_SWAP);
  wire logic [rpra_pkg::ROW_W-1:0] row_select_field =
    ptr_reg[rpra_pkg::PTR_W-1 -: rpra_pkg::ROW_W];
  wire logic [rpra_pkg::DIG_W-1:0] digit_select_field =
    ptr_reg[rpra_pkg::DIG_W-1:0];
  // Top digit bit is dropped, so two digit codes alias one nibble
  wire logic [rpra_pkg::DS_IDX_W-1:0] ptr_idx =
    {row_select_field, digit_select_field[2:0]};
  wire logic [rpra_pkg::DS_IDX_W-1:0] direct_idx =
    {rpra_pkg::DIRECT_ROW, rpra_pkg::DIRECT_DIGIT[2:0]};
  wire logic [rpra_pkg::DS_IDX_W-1:0] ds_idx =
    is_direct ? direct_idx : ptr_idx;
  logic [rpra_pkg::NIB_W-1:0] pointed_nibble;
  wire logic is_swap = (dop == rpra_pkg::DM_EXCHANGE) || is_direct ||
                       (dop == rpra_pkg::DM_SWAP_INCR) ||
                       (dop == rpra_pkg::DM_SWAP_DECR);
  wire logic ds_we_op = is_swap || (dop == rpra_pkg::DM_STORE_WORK) ||
                        (dop == rpra_pkg::DM_FROM_PORT);
  wire logic ds_we = cycle_en && ds_we_op;
  // Port feeds the low nibble of the segment lines
  wire logic [rpra_pkg::NIB_W-1:0] ds_wdata =
    (dop == rpra_pkg::DM_FROM_PORT) ?
    SEG_PORT[rpra_pkg::NIB_W-1:0] : work_reg;
  wire logic [rpra_pkg::DIG_W-1:0] dig_up = digit_select_field + 4'h1;
  wire logic [rpra_pkg::DIG_W-1:0] dig_dn = digit_select_field - 4'h1;

  rpra_data_store i_rpra_data_store (
    .clk(CLK),
    .idx(ds_idx),
    .we(ds_we),
    .wdata(ds_wdata),
    .rdata(pointed_nibble)
  );

  // Work nibble is where most data moves start or end
  assign work_next =
    (is_swap || dop == rpra_pkg::DM_LOAD_WORK) ? pointed_nibble :
    (dop == rpra_pkg::DM_LOAD_IMM) ? DATA_CMD.value[3:0] :
    work_reg;
  assign latch_next = (dop == rpra_pkg::DM_TO_LATCH) ?
                      pointed_nibble : latch_reg;

  // Pointer update; digit steps wrap in four bits, row is kept
  assign ptr_next =
    (dop == rpra_pkg::DM_LOAD_PTR) ? DATA_CMD.value :
    (dop == rpra_pkg::DM_SWAP_INCR) ? {row_select_field, dig_up} :
    (dop == rpra_pkg::DM_SWAP_DECR) ? {row_select_field, dig_dn} :
    ptr_reg;

  // Skip only on the 15/0 wrap; 7/8 is a plain step
  assign skip_next =
    ((dop == rpra_pkg::DM_SWAP_INCR) &&
     (digit_select_field == rpra_pkg::DIGIT_TOP)) ||
    ((dop == rpra_pkg::DM_SWAP_DECR) &&
     (digit_select_field == rpra_pkg::DIGIT_BOTTOM));

  // Data registers step once per instruction cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      work_reg <= rpra_pkg::NIB_RESET;
      ptr_reg <= rpra_pkg::PTR_RESET;
      latch_reg <= rpra_pkg::NIB_RESET;
      skip_reg <= 1'b0;
    end else if (cycle_en) begin
      work_reg <= work_next;
      ptr_reg <= ptr_next;
      latch_reg <= latch_next;
      skip_reg <= skip_next;
    end
  end

  // Strobes follow the digit field; a copy keeps the port flopped
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      strobe_reg <= rpra_pkg::DIGIT_BOTTOM;
    end else if (cycle_en) begin
      strobe_reg <= ptr_next[rpra_pkg::DIG_W-1:0];
    end
  end

  //==========================================================================
  // Outputs
  //==========================================================================
  assign CYCLE = cyc_reg;
  assign PC = pc_reg;
  assign INSTR = instr_reg;
  assign WORK_NIBBLE = work_reg;
  assign RAM_PTR = ptr_reg;
  assign STROBE = strobe_reg;
  assign OUT_LATCH = latch_reg;
  assign SKIP = skip_reg;

endmodule

//--- rtl/rpra_data_store.sv
`timescale 1ns/100ps
module rpra_data_store (
  input wire logic clk,
  input wire logic [rpra_pkg::DS_IDX_W-1:0] idx,
  input wire logic we,
  input wire logic [rpra_pkg::NIB_W-1:0] wdata,
  output logic [rpra_pkg::NIB_W-1:0] rdata
);

  //==========================================================================
  // Storage
  //==========================================================================
  // 32 nibbles, index is {row, digit low bits}
  logic [rpra_pkg::NIB_W-1:0] mem [rpra_pkg::DS_WORDS];

  // Read is combinational so a swap sees the old value
  assign rdata = mem[idx];

  // No reset on purpose: contents must survive a reset
  always_ff @(posedge clk) begin
    if (we) begin
      mem[idx] <= wdata;
    end
  end

endmodule

//--- rtl/rpra_pkg.sv
//==========================================================================
// Functional notes
// - Program store of 512 eight-bit words
// - Program store viewed as 8 pages of 64
// - 9-bit counter is the word address
// - Counter reloads each cycle, plus one normally
// - Two 9-bit return slots form LIFO stack
// - Data store: 4 rows of 8 nibbles
// - 6-bit pointer: 2 row bits, 4 digit bits
// - Digit field top bit ignored for selection
// - Pointed nibble moves with work nibble, latch, port
// - Direct swap addresses row 3, digit 15
// - Digit field drives strobe outputs directly
// - Swap-step skips on 15/0 wrap only
// - Work nibble is main data source, destination
// - Reset clears counter, work nibble, pointer, strobes
// - Reset leaves data store contents alone
//==========================================================================
package rpra_pkg;

  //==========================================================================
  // Sizes
  //==========================================================================
  localparam int PC_W = 9;          // Program counter width
  localparam int ROM_WORDS = 512;   // Program store depth
  localparam int ROM_W = 8;         // Program word width
  localparam int PAGE_BITS = 3;     // 8 pages
  localparam int OFFS_BITS = 6;     // 64 words per page
  localparam int PTR_W = 6;         // Data pointer width
  localparam int ROW_W = 2;         // Row select width
  localparam int DIG_W = 4;         // Digit select width
  localparam int NIB_W = 4;         // Nibble width
  localparam int DS_WORDS = 32;     // 4 rows of 8 digits
  localparam int DS_IDX_W = 5;      // Data store index width

  //==========================================================================
  // Reset values and fixed addresses
  //==========================================================================
  localparam logic [PC_W-1:0] PC_RESET = 9'h000;
  localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
  localparam logic [ROW_W-1:0] DIRECT_ROW = 2'h3;
  localparam logic [DIG_W-1:0] DIRECT_DIGIT = 4'hf;
  localparam logic [DIG_W-1:0] DIGIT_TOP = 4'hf;
  localparam logic [DIG_W-1:0] DIGIT_BOTTOM = 4'h0;

  //==========================================================================
  // Instruction cycle divider
  //==========================================================================
  localparam int CYCLE_DIV = 4;     // System clocks per instruction cycle
  localparam logic [7:0] DIV_LAST = 8'(CYCLE_DIV - 1);

  //==========================================================================
  // Commands
  //==========================================================================
  typedef enum logic [2:0] {
    PC_NEXT,        // Sequential advance
    PC_JUMP,        // Absolute 9-bit target
    PC_PAGE_JUMP,   // Offset within current page
    PC_CALL,        // Absolute call
    PC_PAGE_CALL,   // Call within current page
    PC_RET,         // Return
    PC_INDIRECT     // Jump to offset held in current page
  } rpra_flow_op_type;

  typedef enum logic [3:0] {
    DM_NONE,        // No data action
    DM_LOAD_WORK,   // Work nibble takes pointed nibble
    DM_STORE_WORK,  // Pointed nibble takes work nibble
    DM_EXCHANGE,    // Swap work and pointed nibble
    DM_TO_LATCH,    // Output latch takes pointed nibble
    DM_FROM_PORT,   // Pointed nibble takes segment port
    DM_DIRECT_SWAP, // Swap with fixed location
    DM_SWAP_INCR,   // Swap, step digit up, wrap test
    DM_SWAP_DECR,   // Swap, step digit down, wrap test
    DM_LOAD_PTR,    // Pointer takes immediate
    DM_LOAD_IMM     // Work nibble takes immediate
  } rpra_data_op_type;

  typedef struct packed {
    rpra_flow_op_type op;
    logic [PC_W-1:0] target;
  } rpra_flow_cmd_type;

  typedef struct packed {
    rpra_data_op_type op;
    logic [PTR_W-1:0] value;
  } rpra_data_cmd_type;

endpackage

//--- testbench/rpra_core_bench.sv
`timescale 1ns/100ps
//=======================
// Self-checking bench for the core
module rpra_core_bench;
  logic clk; // 250 MHz clock
  logic reset; // Active high
  rpra_pkg::rpra_flow_cmd_type flow_cmd; // Held for a whole cycle
  rpra_pkg::rpra_data_cmd_type data_cmd;
  logic [7:0] seg_port; // Low nibble is used
  logic prog_we;
  logic [8:0] prog_addr;
  logic [7:0] prog_data;
  logic cycle;
  logic [8:0] pc;
  logic [7:0] instr;
  logic [3:0] work;
  logic [5:0] ptr;
  logic [3:0] strobe;
  logic [3:0] latch;
  logic skip;
  int n_mismatch;
  int n_checks;
  // Digit step table: start pointer, up or down, end pointer, skip
  localparam logic [5:0] SW_FROM [5] = '{6'h0f, 6'h07, 6'h08, 6'h00, 6'h3f};
  localparam logic [5:0] SW_TO [5] = '{6'h00, 6'h08, 6'h07, 6'h0f, 6'h30};
  localparam logic [4:0] SW_UP = 5'h13; // Bit i for entry i
  localparam logic [4:0] SW_SKIP = 5'h19;

  rpra_core i_rpra_core (.CLK(clk), .RESET(reset), .FLOW_CMD(flow_cmd),
    .DATA_CMD(data_cmd), .SEG_PORT(seg_port), .PROG_WE(prog_we),
    .PROG_ADDR(prog_addr), .PROG_DATA(prog_data), .CYCLE(cycle), .PC(pc),
    .INSTR(instr), .WORK_NIBBLE(work), .RAM_PTR(ptr), .STROBE(strobe),
    .OUT_LATCH(latch), .SKIP(skip));

  //=======================
  // Helpers
  // Program word pattern; the top address bit flips bit 7 of the word
  function automatic logic [7:0] pat(input logic [8:0] a);
    pat = a[7:0] ^ {a[8], 7'h16};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One instruction cycle: present both commands, wait for the cycle pulse
  task automatic step(input rpra_pkg::rpra_flow_op_type f,
    input logic [8:0] t, input rpra_pkg::rpra_data_op_type d,
    input logic [5:0] v);
    int i;
    @(negedge clk);
    flow_cmd = '{op: f, target: t};
    data_cmd = '{op: d, value: v};
    for (i = 0; i < 12; i++) begin
      @(negedge clk);
      if (cycle === 1'b1) break;
    end
    if (i == 12) begin
      n_mismatch++;
      end_of_test();
    end
    chk("program word", 32'(pat(pc)), 32'(instr));
  endtask

  task automatic dstep(input rpra_pkg::rpra_data_op_type d,
    input logic [5:0] v);
    step(rpra_pkg::PC_NEXT, 9'h000, d, v);
  endtask

  // Reset is held 8 clocks; the data store must survive it
  task automatic do_reset();
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    chk("reset state", 32'h0,
      32'({pc, work, ptr, strobe, latch, skip}));
  endtask

  //=======================
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    int a;
    reset = 1'b1;
    flow_cmd = '0;
    data_cmd = '0;
    seg_port = 8'h95;
    prog_we = 1'b0;
    prog_addr = 9'h000;
    prog_data = 8'h00;
    n_mismatch = 0;
    n_checks = 0;
    do_reset();
    // Fill the whole program store, one word per clock
    for (a = 0; a < 512; a++) begin
      @(negedge clk);
      prog_we = 1'b1;
      prog_addr = 9'(a);
      prog_data = pat(9'(a));
    end
    @(negedge clk);
    prog_we = 1'b0;
    // Flow control: jumps, wrap, page view, indirect, nested calls
    step(rpra_pkg::PC_JUMP, 9'h1ff, rpra_pkg::DM_NONE, 6'h00);
    chk("pc jump", 32'h1ff, 32'(pc));
    dstep(rpra_pkg::DM_NONE, 6'h00);
    chk("pc wrap", 32'h000, 32'(pc));
    step(rpra_pkg::PC_JUMP, 9'h0c7, rpra_pkg::DM_NONE, 6'h00);
    step(rpra_pkg::PC_PAGE_JUMP, 9'h1fe, rpra_pkg::DM_NONE, 6'h00);
    chk("pc page jump", 32'h0fe, 32'(pc));
    step(rpra_pkg::PC_INDIRECT, 9'h005, rpra_pkg::DM_NONE, 6'h00);
    chk("pc indirect", 32'h0c0 | 32'(pat(9'h0c5) & 8'h3f), 32'(pc));
    step(rpra_pkg::PC_CALL, 9'h123, rpra_pkg::DM_NONE, 6'h00);
    chk("pc call", 32'h123, 32'(pc));
    step(rpra_pkg::PC_PAGE_CALL, 9'h00a, rpra_pkg::DM_NONE, 6'h00);
    chk("pc page call", 32'h10a, 32'(pc));
    step(rpra_pkg::PC_RET, 9'h000, rpra_pkg::DM_NONE, 6'h00);
    chk("pc return inner", 32'h124, 32'(pc));
    step(rpra_pkg::PC_RET, 9'h000, rpra_pkg::DM_NONE, 6'h00);
    chk("pc return outer", 32'h0d4, 32'(pc));
    // Data store moves, aliasing and the fixed location
    dstep(rpra_pkg::DM_LOAD_PTR, 6'h3f);
    chk("strobe", 32'hf, 32'(strobe));
    dstep(rpra_pkg::DM_LOAD_IMM, 6'h0a);
    dstep(rpra_pkg::DM_STORE_WORK, 6'h00);
    dstep(rpra_pkg::DM_LOAD_PTR, 6'h37);
    dstep(rpra_pkg::DM_LOAD_IMM, 6'h00);
    dstep(rpra_pkg::DM_LOAD_WORK, 6'h00);
    chk("work alias", 32'ha, 32'(work));
    dstep(rpra_pkg::DM_TO_LATCH, 6'h00);
    chk("latch", 32'ha, 32'(latch));
    dstep(rpra_pkg::DM_LOAD_PTR, 6'h00);
    dstep(rpra_pkg::DM_LOAD_IMM, 6'h06);
    dstep(rpra_pkg::DM_DIRECT_SWAP, 6'h00);
    chk("work direct", 32'ha, 32'(work));
    dstep(rpra_pkg::DM_FROM_PORT, 6'h00);
    dstep(rpra_pkg::DM_EXCHANGE, 6'h00);
    chk("work exchange", 32'h5, 32'(work));
    // Store contents across a mid-run reset
    do_reset();
    dstep(rpra_pkg::DM_LOAD_PTR, 6'h3f);
    dstep(rpra_pkg::DM_LOAD_WORK, 6'h00);
    chk("work direct kept", 32'h6, 32'(work));
    dstep(rpra_pkg::DM_LOAD_PTR, 6'h08);
    dstep(rpra_pkg::DM_LOAD_WORK, 6'h00);
    chk("work exchange kept", 32'ha, 32'(work));
    // Digit step wrap tests
    for (a = 0; a < 5; a++) begin
      dstep(rpra_pkg::DM_LOAD_PTR, SW_FROM[a]);
      dstep(SW_UP[a] ? rpra_pkg::DM_SWAP_INCR : rpra_pkg::DM_SWAP_DECR, 6'h00);
      chk("pointer step", 32'(SW_TO[a]), 32'(ptr));
      chk("skip", 32'(SW_SKIP[a]), 32'(skip));
    end
    dstep(rpra_pkg::DM_NONE, 6'h00);
    chk("skip idle", 32'h0, 32'(skip));
    end_of_test();
  end
endmodule

//--- testbench/rpra_core_monitor.sv
`timescale 1ns/100ps
//=======================
// Port checker for the core
module rpra_core_monitor (
  input wire logic CLK,
  input wire logic RESET,
  input rpra_pkg::rpra_flow_cmd_type FLOW_CMD,
  input rpra_pkg::rpra_data_cmd_type DATA_CMD,
  input wire logic [7:0] SEG_PORT,
  input wire logic PROG_WE,
  input wire logic [8:0] PROG_ADDR,
  input wire logic [7:0] PROG_DATA,
  input wire logic CYCLE,
  input wire logic [8:0] PC,
  input wire logic [7:0] INSTR,
  input wire logic [3:0] WORK_NIBBLE,
  input wire logic [5:0] RAM_PTR,
  input wire logic [3:0] STROBE,
  input wire logic [3:0] OUT_LATCH,
  input wire logic SKIP
);
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  //=======================
  // Assertions; CYCLE high means the last edge was a cycle edge
  strobe_mirror_a: assert property (STROBE == RAM_PTR[3:0])
    else $error("strobe differs from digit field");
  cycle_period_a: assert property (CYCLE |=> !CYCLE [*3] ##1 CYCLE)
    else $error("cycle pulse spacing wrong");
  pc_hold_a: assert property (!CYCLE |-> $stable(PC))
    else $error("counter moved between cycle edges");
  pc_incr_a: assert property (CYCLE &&
    $past(FLOW_CMD.op) == rpra_pkg::PC_NEXT |-> PC == 9'($past(PC) + 1))
    else $error("counter did not advance by one");
  page_jump_a: assert property (CYCLE &&
    $past(FLOW_CMD.op) == rpra_pkg::PC_PAGE_JUMP
    |-> PC == {$past(PC[8:6]), $past(FLOW_CMD.target[5:0])})
    else $error("page jump left its page");
  abs_jump_a: assert property (CYCLE &&
    $past(FLOW_CMD.op) == rpra_pkg::PC_JUMP |-> PC == $past(FLOW_CMD.target))
    else $error("jump target not taken");
  ptr_load_a: assert property (CYCLE &&
    $past(DATA_CMD.op) == rpra_pkg::DM_LOAD_PTR
    |-> RAM_PTR == $past(DATA_CMD.value))
    else $error("pointer load wrong");
  incr_skip_a: assert property (CYCLE &&
    $past(DATA_CMD.op) == rpra_pkg::DM_SWAP_INCR
    |-> SKIP == ($past(RAM_PTR[3:0]) == 4'hf)
    && RAM_PTR[3:0] == 4'($past(RAM_PTR[3:0]) + 4'h1))
    else $error("step up skip or digit wrong");
  decr_skip_a: assert property (CYCLE &&
    $past(DATA_CMD.op) == rpra_pkg::DM_SWAP_DECR
    |-> SKIP == ($past(RAM_PTR[3:0]) == 4'h0)
    && RAM_PTR[3:0] == 4'($past(RAM_PTR[3:0]) - 4'h1))
    else $error("step down skip or digit wrong");
  reset_clear_a: assert property (disable iff (1'b0) RESET |=>
    PC == 9'h000 && WORK_NIBBLE == 4'h0 && RAM_PTR == 6'h00 && !SKIP)
    else $error("reset state wrong");
  //=======================
  // Main scenarios
  call_c: cover property (CYCLE && $past(FLOW_CMD.op) == rpra_pkg::PC_CALL);
  ind_c: cover property (CYCLE && $past(FLOW_CMD.op) == rpra_pkg::PC_INDIRECT);
  skip_c: cover property (CYCLE && SKIP);
endmodule
bind rpra_core rpra_core_monitor i_rpra_core_monitor (.CLK, .RESET,
  .FLOW_CMD, .DATA_CMD, .SEG_PORT, .PROG_WE, .PROG_ADDR, .PROG_DATA, .CYCLE,
  .PC, .INSTR, .WORK_NIBBLE, .RAM_PTR, .STROBE, .OUT_LATCH, .SKIP);
